//--- src/cca_pkg.sv
package cca_pkg;
	// Structure
	localparam int NUM_MOD = 5;
	localparam int WD_MOD = 4;
	localparam int ADDR_W = 8;
	localparam int SEL_W = 3;
	localparam int MODE_W = 3;
	localparam int MODE_REG_W = 5;
	// Byte offsets of the register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_MODE0 = 8'h10;
	localparam logic [7:0] OFS_CMP0 = 8'h30;
	localparam logic [7:0] OFS_WD_CTRL = 8'h50;
	localparam logic [7:0] OFS_WD_KICK = 8'h54;
	localparam logic [7:0] OFS_STAT = 8'h58;
	localparam logic [7:0] OFS_CLR = 8'h5C;
	localparam logic [7:0] OFS_INTEN = 8'h60;
	// Field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int MODE_LSB = 0;
	localparam int CAP_POS_BIT = 3;
	localparam int CAP_NEG_BIT = 4;
	localparam int WD_EN_BIT = 0;
	localparam int WD_LOCK_BIT = 1;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_MOD_LSB = 1;
	// Reset values
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] WD_CMP_RST = 16'hFF00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// Time base dividers
	localparam logic [3:0] DIV_SYS12 = 4'hC;
	localparam logic [1:0] DIV_SYS4_M1 = 2'h3;
	localparam logic [2:0] DIV_XOSC_M1 = 3'h7;
	typedef enum logic [2:0] {
		SRC_SYS12, SRC_SYS4, SRC_T0, SRC_ECI, SRC_SYS, SRC_XOSC8
	} cca_src_e;
	typedef enum logic [2:0] {
		MD_OFF, MD_CAPTURE, MD_SWTIMER, MD_HSO, MD_PWM8, MD_PWM16, MD_FREQ
	} cca_mode_e;
endpackage

//--- src/cca_top.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module cca_top
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [cca_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Time base sources and debug
	input wire logic timer0_ovf,
	input wire logic ext_count_input,
	input wire logic ext_osc_clk,
	input wire logic core_halted,
	// Crossbar side of the modules
	input wire logic [cca_pkg::NUM_MOD-1:0] cap_in,
	output logic [cca_pkg::NUM_MOD-1:0] cmp_out,
	// System
	output logic irq,
	output logic module_watchdog_rst
);
	import cca_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic [7:0] mod_ofs(input logic [7:0] base, input int k);
		return base + 8'(4 * k);
	endfunction

	// Bus handshake: one wait cycle, write commits on the released edge
	logic ack_q;
	logic [31:0] readdata_q;
	logic [31:0] rdata;
	wire req = avs_read | avs_write;
	wire wr_en = avs_write & ack_q;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = readdata_q;

	// Registers
	logic ctrl_run_q;
	logic [SEL_W-1:0] ctrl_sel_q;
	logic [15:0] count_q;
	logic wd_en_q;
	logic wd_lock_q;
	logic [NUM_MOD:0] stat_q;
	logic [NUM_MOD:0] inten_q;
	logic irq_q;
	logic wd_rst_q;
	logic [MODE_REG_W-1:0] mode_q [NUM_MOD];
	logic [15:0] cp_q [NUM_MOD];
	logic [NUM_MOD-1:0] out_q;
	logic [NUM_MOD-1:0] mod_ev;

	// Pin synchronisers, third stage only for edge detection
	logic [1:0] eci_s_q;
	logic eci_d_q;
	logic [1:0] xosc_s_q;
	logic xosc_d_q;
	logic [NUM_MOD-1:0] cap_s1_q;
	logic [NUM_MOD-1:0] cap_s2_q;
	logic [NUM_MOD-1:0] cap_d_q;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			eci_s_q <= 2'h0;
			eci_d_q <= 1'b0;
			xosc_s_q <= 2'h0;
			xosc_d_q <= 1'b0;
			cap_s1_q <= '0;
			cap_s2_q <= '0;
			cap_d_q <= '0;
		end
		else
		begin
			eci_s_q <= {eci_s_q[0], ext_count_input};
			eci_d_q <= eci_s_q[1];
			xosc_s_q <= {xosc_s_q[0], ext_osc_clk};
			xosc_d_q <= xosc_s_q[1];
			cap_s1_q <= cap_in;
			cap_s2_q <= cap_s1_q;
			cap_d_q <= cap_s2_q;
		end
	end

	wire eci_rise = eci_s_q[1] & ~eci_d_q;
	// Sampled oscillator must stay below half of core_clk
	wire xosc_rise = xosc_s_q[1] & ~xosc_d_q;
	wire [NUM_MOD-1:0] cap_rise = cap_s2_q & ~cap_d_q;
	wire [NUM_MOD-1:0] cap_fall = ~cap_s2_q & cap_d_q;

	// Prescalers
	logic [3:0] pre12_q;
	logic [1:0] pre4_q;
	logic [2:0] xosc_cnt_q;
	wire tick12 = pre12_q == DIV_SYS12 - 4'h1;
	wire tick4 = pre4_q == DIV_SYS4_M1;
	wire tick_x8 = xosc_rise & (xosc_cnt_q == DIV_XOSC_M1);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre12_q <= 4'h0;
			pre4_q <= 2'h0;
			xosc_cnt_q <= 3'h0;
		end
		else
		begin
			pre12_q <= tick12 ? 4'h0 : pre12_q + 4'h1;
			pre4_q <= pre4_q + 2'h1;
			if (xosc_rise)
				xosc_cnt_q <= xosc_cnt_q + 3'h1;
		end
	end

	logic src_tick;
	always_comb
	begin
		unique case (cca_src_e'(ctrl_sel_q))
			SRC_SYS12: src_tick = tick12;
			SRC_SYS4: src_tick = tick4;
			SRC_T0: src_tick = timer0_ovf;
			SRC_ECI: src_tick = eci_rise;
			SRC_SYS: src_tick = 1'b1;
			SRC_XOSC8: src_tick = tick_x8;
			default: src_tick = 1'b0;
		endcase
	end

	// Watchdog keeps the time base running even with run cleared
	wire tick = src_tick & (ctrl_run_q | wd_en_q) & ~core_halted;
	wire ovf = tick & (count_q == 16'hFFFF);

	// Register writes
	wire wr_ctrl = wr_en & hit(avs_address, OFS_CTRL);
	wire wr_count = wr_en & hit(avs_address, OFS_COUNT);
	wire wr_wd = wr_en & hit(avs_address, OFS_WD_CTRL);
	wire wr_kick = wr_en & hit(avs_address, OFS_WD_KICK);
	wire wr_clr = wr_en & hit(avs_address, OFS_CLR);
	wire wr_inten = wr_en & hit(avs_address, OFS_INTEN);
	wire [NUM_MOD:0] clr_mask = wr_clr ? avs_writedata[NUM_MOD:0] : '0;
	wire [NUM_MOD:0] ev_all = {mod_ev, ovf};
	wire [NUM_MOD:0] stat_d = (stat_q & ~clr_mask) | ev_all;
	wire wd_timeout = wd_en_q & tick & (count_q[15:8] == cp_q[WD_MOD][15:8])
		& (count_q[7:0] == 8'hFF);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0;
			ctrl_run_q <= 1'b0;
			ctrl_sel_q <= '0;
			count_q <= COUNT_RST;
			wd_en_q <= 1'b1;
			wd_lock_q <= 1'b0;
			stat_q <= '0;
			inten_q <= '0;
			irq_q <= 1'b0;
			wd_rst_q <= 1'b0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q)
				readdata_q <= rdata;
			if (wr_ctrl)
			begin
				ctrl_run_q <= avs_writedata[CTRL_RUN_BIT];
				ctrl_sel_q <= avs_writedata[CTRL_SEL_LSB +: SEL_W];
			end
			if (wr_count)
				count_q <= avs_writedata[15:0];
			else if (tick)
				count_q <= count_q + 16'h1;
			if (wr_wd)
			begin
				wd_lock_q <= wd_lock_q | avs_writedata[WD_LOCK_BIT];
				wd_en_q <= wd_lock_q | avs_writedata[WD_LOCK_BIT]
					| avs_writedata[WD_EN_BIT];
			end
			stat_q <= stat_d;
			if (wr_inten)
				inten_q <= avs_writedata[NUM_MOD:0];
			irq_q <= |(stat_q & inten_q);
			wd_rst_q <= wd_timeout;
		end
	end

	assign irq = irq_q;
	assign module_watchdog_rst = wd_rst_q;
	assign cmp_out = out_q;

	// Capture/compare modules
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MOD; gi++)
		begin : g_mod
			wire wr_mode = wr_en & hit(avs_address, mod_ofs(OFS_MODE0, gi));
			wire wr_cp = wr_en & hit(avs_address, mod_ofs(OFS_CMP0, gi));
			wire is_wd = (gi == WD_MOD) && wd_en_q;
			wire [MODE_W-1:0] md_raw = mode_q[gi][MODE_LSB +: MODE_W];
			wire [MODE_W-1:0] md = is_wd ? MODE_W'(MD_OFF) : md_raw;
			wire cap_ev = (cap_rise[gi] & mode_q[gi][CAP_POS_BIT])
				| (cap_fall[gi] & mode_q[gi][CAP_NEG_BIT]);
			wire m16 = tick & (count_q == cp_q[gi]);
			wire m8 = tick & (count_q[7:0] == cp_q[gi][7:0]);
			logic ev;
			logic out_d;
			always_comb
			begin
				ev = 1'b0;
				out_d = out_q[gi];
				unique case (cca_mode_e'(md))
					MD_OFF: out_d = 1'b0;
					MD_CAPTURE: ev = cap_ev;
					MD_SWTIMER: ev = m16;
					MD_HSO:
					begin
						ev = m16;
						out_d = out_q[gi] ^ m16;
					end
					MD_PWM8:
					begin
						ev = m8;
						out_d = count_q[7:0] < cp_q[gi][7:0];
					end
					MD_PWM16:
					begin
						ev = m16;
						out_d = count_q < cp_q[gi];
					end
					MD_FREQ:
					begin
						ev = m8;
						out_d = out_q[gi] ^ m8;
					end
					default: out_d = 1'b0;
				endcase
			end
			assign mod_ev[gi] = ev;

			always_ff @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					mode_q[gi] <= '0;
					cp_q[gi] <= (gi == WD_MOD) ? WD_CMP_RST : CMP_RST;
					out_q[gi] <= 1'b0;
				end
				else
				begin
					if (wr_mode)
						mode_q[gi] <= avs_writedata[MODE_REG_W-1:0];
					if (wr_cp)
						cp_q[gi] <= avs_writedata[15:0];
					else if ((gi == WD_MOD) && wr_kick)
						cp_q[gi][15:8] <= count_q[15:8] + avs_writedata[7:0];
					else if (md == MODE_W'(MD_CAPTURE) && cap_ev)
						cp_q[gi] <= count_q;
					else if (md == MODE_W'(MD_FREQ) && m8)
						cp_q[gi][7:0] <= cp_q[gi][7:0] + cp_q[gi][15:8];
					out_q[gi] <= out_d;
				end
			end
		end
	endgenerate

	// Read mux; unmapped and write-only offsets read zero
	always_comb
	begin
		rdata = 32'h0;
		if (hit(avs_address, OFS_CTRL))
			rdata = {28'h0, ctrl_sel_q, ctrl_run_q};
		if (hit(avs_address, OFS_COUNT))
			rdata = {16'h0, count_q};
		if (hit(avs_address, OFS_WD_CTRL))
			rdata = {30'h0, wd_lock_q, wd_en_q};
		if (hit(avs_address, OFS_STAT))
			rdata = {26'h0, stat_q};
		if (hit(avs_address, OFS_INTEN))
			rdata = {26'h0, inten_q};
		for (int k = 0; k < NUM_MOD; k++)
		begin
			if (hit(avs_address, mod_ofs(OFS_MODE0, k)))
				rdata = {27'h0, mode_q[k]};
			if (hit(avs_address, mod_ofs(OFS_CMP0, k)))
				rdata = {16'h0, cp_q[k]};
		end
	end
endmodule

//--- verif/cca_chk_sva.sv
`timescale 1ns/1ps
module cca_chk
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Rest
	input wire logic core_halted,
	input wire logic [4:0] cmp_out,
	input wire logic irq,
	input wire logic module_watchdog_rst
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("no wait on read");
	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	wait_idle_a: assert property (avs_waitrequest |-> avs_read || avs_write)
		else $error("wait while idle");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	irq_clear_a: assert property ($fell(irq) |-> $past(avs_write, 2))
		else $error("irq fell alone");
	wd_pulse_a: assert property (module_watchdog_rst |=> !module_watchdog_rst)
		else $error("long reset pulse");
	halt_wd_a: assert property (core_halted && $past(core_halted) |-> !module_watchdog_rst)
		else $error("timeout in halt");
	// Writes excluded since a new compare value may move an output
	halt_out_a: assert property ((core_halted && !avs_write)[*3] |-> $stable(cmp_out))
		else $error("output moved in halt");
endmodule

bind cca_top cca_chk chk_u (.core_clk, .arst_n, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .core_halted, .cmp_out, .irq, .module_watchdog_rst);

//--- verif/cca_pins.sv
`timescale 1ns/1ps
module cca_pins
(
	// Clock
	input wire logic core_clk,
	// Pins
	output logic ext_count_input,
	output logic ext_osc_clk,
	output logic [4:0] cap_in
);
	initial
	begin
		ext_count_input = 1'h0;
		ext_osc_clk = 1'h0;
		cap_in = 5'h00;
	end
	// Oscillator at a quarter of core_clk, slow enough for the sampler
	task automatic osc(input int n);
		repeat (2 * n)
		begin
			repeat (2) @(posedge core_clk);
			ext_osc_clk <= ~ext_osc_clk;
		end
	endtask
	// Slow edges so the two-flop sync sees each one
	task automatic edges(input int n);
		repeat (2 * n)
		begin
			repeat (4) @(posedge core_clk);
			ext_count_input <= ~ext_count_input;
		end
	endtask
	task cap(input int i);
		@(posedge core_clk);
		cap_in[i] <= 1'h1;
	endtask
endmodule

//--- verif/counter_array_capture_compare_test.sv
`timescale 1ns/1ps
module counter_array_capture_compare_test;
	import cca_pkg::*;
	logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, timer0_ovf;
	logic ext_count_input, ext_osc_clk, core_halted, irq, module_watchdog_rst;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [4:0] cap_in, cmp_out;
	int err_count, compares;
	cca_top dut_u (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .timer0_ovf, .ext_count_input, .ext_osc_clk,
		.core_halted, .cap_in, .cmp_out, .irq, .module_watchdog_rst);
	cca_pins pins_u (.core_clk, .ext_count_input, .ext_osc_clk, .cap_in);
	initial
	begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic give_verdict;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Read right after the edge, so the pre-edge handshake values are seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 20);
		if (n >= 20)
			err_count++;
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		cmp(q, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wdw(input logic e);
		logic s;
		s = 1'h0;
		repeat (40)
		begin
			@(negedge core_clk);
			if (module_watchdog_rst === 1'h1)
				s = 1'h1;
		end
		cmp(32'(s), 32'(e));
	endtask
	task automatic t0(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			timer0_ovf <= 1'h1;
			@(posedge core_clk);
			timer0_ovf <= 1'h0;
		end
	endtask
	// Window of 48 edges holds a whole number of periods of every divider
	task automatic rate(input logic [31:0] c, input logic [31:0] e);
		wr(OFS_CTRL, c);
		wr(OFS_COUNT, 32'h0);
		repeat (47) @(posedge core_clk);
		rdc(OFS_COUNT, e);
	endtask
	task automatic t_reset;
		rdc(OFS_WD_CTRL, 32'h1);
		rdc(OFS_CMP0 + 8'h10, 32'(WD_CMP_RST));
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_CLR, 32'h0);
		rdc(8'hFC, 32'h0);
		$display("reset values done");
	endtask
	task automatic t_src;
		wr(OFS_CTRL, 32'h5);
		wr(OFS_COUNT, 32'h0);
		t0(5);
		rdc(OFS_COUNT, 32'h5);
		wr(OFS_CTRL, 32'h7);
		pins_u.edges(3);
		rdc(OFS_COUNT, 32'h8);
		core_halted <= 1'h1;
		wr(OFS_CTRL, 32'h9);
		wr(OFS_COUNT, 32'h1234);
		idle(10);
		rdc(OFS_COUNT, 32'h1234);
		core_halted <= 1'h0;
		$display("time base done");
	endtask
	task automatic t_mode;
		wr(OFS_CTRL, 32'h5);
		wr(OFS_COUNT, 32'h42);
		wr(OFS_MODE0, 32'h9);
		pins_u.cap(0);
		idle(8);
		rdc(OFS_CMP0, 32'h42);
		rdc(OFS_STAT, 32'h2);
		wr(OFS_MODE0 + 8'h4, 32'h5);
		wr(OFS_CMP0 + 8'h4, 32'h50);
		idle(3);
		cmp(32'(cmp_out[1]), 32'h1);
		wr(OFS_COUNT, 32'h60);
		idle(3);
		cmp(32'(cmp_out[1]), 32'h0);
		wr(OFS_MODE0 + 8'h4, 32'h0);
		cmp(32'(irq), 32'h0);
		wr(OFS_INTEN, 32'h2);
		idle(2);
		cmp(32'(irq), 32'h1);
		wr(OFS_CLR, 32'h2);
		idle(2);
		cmp(32'(irq), 32'h0);
		wr(OFS_INTEN, 32'h0);
		wr(OFS_MODE0 + 8'h8, 32'h3);
		wr(OFS_CMP0 + 8'h8, 32'h62);
		t0(3);
		idle(2);
		cmp(32'(cmp_out[2]), 32'h1);
		rdc(OFS_STAT, 32'h8);
		wr(OFS_CLR, 32'h3F);
		wr(OFS_MODE0 + 8'hC, 32'h4);
		wr(OFS_CMP0 + 8'hC, 32'h80);
		wr(OFS_COUNT, 32'h110);
		idle(3);
		cmp(32'(cmp_out[3]), 32'h1);
		wr(OFS_MODE0, 32'h6);
		wr(OFS_CMP0, 32'h312);
		wr(OFS_MODE0 + 8'h4, 32'h2);
		wr(OFS_CMP0 + 8'h4, 32'h114);
		t0(5);
		idle(2);
		cmp(32'(cmp_out[0]), 32'h1);
		rdc(OFS_CMP0, 32'h315);
		rdc(OFS_STAT, 32'h6);
		for (int m = 0; m < 4; m++)
			wr(OFS_MODE0 + 8'(4 * m), 32'h0);
		wr(OFS_CLR, 32'h3F);
		$display("modes done");
	endtask
	task automatic t_wd;
		wr(OFS_CTRL, 32'h9);
		wr(OFS_COUNT, 32'hFFF0);
		wdw(1'h1);
		rdc(OFS_STAT, 32'h1);
		wr(OFS_WD_CTRL, 32'h0);
		wr(OFS_COUNT, 32'hFFF0);
		wdw(1'h0);
		wr(OFS_WD_CTRL, 32'h2);
		rdc(OFS_WD_CTRL, 32'h3);
		wr(OFS_WD_CTRL, 32'h0);
		rdc(OFS_WD_CTRL, 32'h3);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_COUNT, 32'h1200);
		wr(OFS_WD_KICK, 32'h3);
		rdc(OFS_CMP0 + 8'h10, 32'h1500);
		wr(OFS_CTRL, 32'h9);
		wr(OFS_COUNT, 32'h15F0);
		wdw(1'h1);
		$display("watchdog done");
	endtask
	task automatic t_div;
		rate(32'h3, 32'(48 / (DIV_SYS4_M1 + 1)));
		rate(32'h1, 32'(48 / DIV_SYS12));
		rate(32'h9, 32'h30);
		wr(OFS_CTRL, 32'hB);
		wr(OFS_COUNT, 32'h0);
		pins_u.osc(16);
		idle(4);
		rdc(OFS_COUNT, 32'(16 / (DIV_XOSC_M1 + 1)));
		$display("dividers done");
	endtask
	// Reset in mid-run must also drop the lock and re-arm the watchdog
	task automatic t_rst2;
		@(posedge core_clk);
		arst_n <= 1'h0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'h1;
		rdc(OFS_WD_CTRL, 32'h1);
		rdc(OFS_CMP0 + 8'h10, 32'(WD_CMP_RST));
		rdc(OFS_STAT, 32'h0);
		$display("second reset done");
	endtask
	initial
	begin
		{arst_n, avs_read, avs_write, timer0_ovf, core_halted} = 5'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		err_count = 0;
		compares = 0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'h1;
		t_reset;
		t_src;
		t_div;
		t_mode;
		t_wd;
		t_rst2;
		give_verdict;
	end
	initial
	begin
		#200000;
		err_count++;
		give_verdict;
	end
endmodule
